//--- src/acpc_config_pin_ctrl.v
/*
 * Converter configuration register, two analog pin control registers,
 * the converter clock source mux and divider, and the pin override
 * outputs toward the port logic.
 * Assumes a plain one-cycle register port on CORE_CLK, and that the
 * alternate and async converter clocks arrive as enables synchronous
 * to CORE_CLK.
 */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "acpc_regs.vh"

module acpc_config_pin_ctrl #(
   parameter NUM_CH = 16
) (
   input  wire                   CORE_CLK,
   input  wire                   SRST,
   input  wire [`ACPC_ADDR_W-1:0] ADDR,
   input  wire [7:0]             WDATA,
   input  wire                   WR,
   input  wire                   RD,
   output wire [7:0]             RDATA,
   input  wire                   ALT_CLK_EN,
   input  wire                   ASYNC_CLK_EN,
   output wire                   CONV_CLK_EN,
   output wire                   LOW_POWER,
   output wire                   LONG_SAMPLE,
   output wire                   MODE_10BIT,
   output wire                   MODE_RESERVED,
   output wire [1:0]             CLK_SOURCE,
   output wire                   RESULT_INVALIDATE,
   input  wire                   RESULT_CAPTURED,
   input  wire [NUM_CH-1:0]      PORT_OUT,
   input  wire [NUM_CH-1:0]      PORT_OE,
   input  wire [NUM_CH-1:0]      PORT_PULLUP,
   input  wire [NUM_CH-1:0]      PIN_IN,
   output wire [NUM_CH-1:0]      PIN_OUT,
   output wire [NUM_CH-1:0]      PIN_OE,
   output wire [NUM_CH-1:0]      PIN_PULLUP,
   output wire [NUM_CH-1:0]      PIN_IN_EN,
   output wire [NUM_CH-1:0]      PORT_IN,
   output wire [NUM_CH-1:0]      ANALOG_SEL
);

   reg  [7:0]        config_q;
   reg  [7:0]        config_d;
   reg  [7:0]        pin_low_q;
   reg  [7:0]        pin_low_d;
   reg  [7:0]        pin_mid_q;
   reg  [7:0]        pin_mid_d;
   reg  [7:0]        rdata_q;
   reg  [7:0]        rdata_d;
   reg               res_valid_q;
   reg               res_valid_d;
   reg               inval_q;
   reg               half_q;
   reg  [2:0]        div_cnt_q;
   reg  [2:0]        div_cnt_d;
   reg               conv_tick_q;
   reg               conv_tick_d;
   reg               src_tick;
   reg  [2:0]        div_mask;
   wire [15:0]       pins_all;
   wire              wr_cfg;
   wire              mode_chg;
   wire              div_wrap;

   assign wr_cfg   = WR && (ADDR == `ACPC_OFS_CONFIG);
   // Only an actual change of the width field invalidates results
   assign mode_chg = wr_cfg &&
      (WDATA[`ACPC_MODE_HI:`ACPC_MODE_LO] != config_q[`ACPC_MODE_HI:`ACPC_MODE_LO]);

   // Register writes; index 3 is read-only status, writes there are dropped
   always @* begin
      config_d  = config_q;
      pin_low_d = pin_low_q;
      pin_mid_d = pin_mid_q;
      if (WR) begin
         case (ADDR)
            `ACPC_OFS_CONFIG:  config_d  = WDATA;
            `ACPC_OFS_PIN_LOW: pin_low_d = WDATA;
            `ACPC_OFS_PIN_MID: pin_mid_d = WDATA;
            default: ;
         endcase
      end
   end

   always @(posedge CORE_CLK) begin
      if (SRST) begin
         config_q  <= `ACPC_RST_CONFIG;
         pin_low_q <= `ACPC_RST_PINS;
         pin_mid_q <= `ACPC_RST_PINS;
      end else begin
         config_q  <= config_d;
         pin_low_q <= pin_low_d;
         pin_mid_q <= pin_mid_d;
      end
   end

   // Result validity: a new capture wins over invalidation in same cycle
   always @* begin
      res_valid_d = res_valid_q;
      if (RESULT_CAPTURED)
         res_valid_d = 1'b1;
      else if (mode_chg)
         res_valid_d = 1'b0;
   end

   always @(posedge CORE_CLK) begin
      if (SRST) begin
         res_valid_q <= 1'b0;
         inval_q     <= 1'b0;
      end else begin
         res_valid_q <= res_valid_d;
         inval_q     <= mode_chg;
      end
   end

   // Readback; status shows result validity and width legality
   // Idle read data is zero so a stale value never looks like a read
   always @* begin
      rdata_d = 8'h00;
      if (RD) begin
         case (ADDR)
            `ACPC_OFS_CONFIG:  rdata_d = config_q;
            `ACPC_OFS_PIN_LOW: rdata_d = pin_low_q;
            `ACPC_OFS_PIN_MID: rdata_d = pin_mid_q;
            `ACPC_OFS_STATUS:  rdata_d = {6'h00, MODE_RESERVED, res_valid_q};
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   always @(posedge CORE_CLK) begin
      if (SRST)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   assign RDATA             = rdata_q;
   assign LOW_POWER         = config_q[`ACPC_BIT_LOW_POWER];
   assign LONG_SAMPLE       = config_q[`ACPC_BIT_LONG_SMP];
   assign MODE_10BIT        =
      (config_q[`ACPC_MODE_HI:`ACPC_MODE_LO] == `ACPC_MODE_10BIT);
   // Reserved encodings are flagged, not remapped; software must avoid them
   assign MODE_RESERVED     = config_q[`ACPC_MODE_LO];
   assign CLK_SOURCE        = config_q[`ACPC_CLK_HI:`ACPC_CLK_LO];
   assign RESULT_INVALIDATE = inval_q;

   // Source select as enable ticks: avoids gating clocks in logic
   always @* begin
      case (CLK_SOURCE)
         `ACPC_SRC_BUS:      src_tick = 1'b1;
         `ACPC_SRC_BUS_HALF: src_tick = half_q;
         `ACPC_SRC_ALT:      src_tick = ALT_CLK_EN;
         `ACPC_SRC_ASYNC:    src_tick = ASYNC_CLK_EN;
         default:            src_tick = 1'b1;
      endcase
   end

   always @* begin
      case (config_q[`ACPC_DIV_HI:`ACPC_DIV_LO])
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         2'h3:    div_mask = 3'h7;
         default: div_mask = 3'h0;
      endcase
   end

   // Divider: one converter tick per 1, 2, 4 or 8 source ticks
   // Counter free-runs, so the first tick after a divide change may come early
   assign div_wrap = ((div_cnt_q & div_mask) == div_mask);

   always @* begin
      div_cnt_d   = div_cnt_q;
      conv_tick_d = src_tick && div_wrap;
      if (src_tick)
         div_cnt_d = div_cnt_q + 3'h1;
   end

   always @(posedge CORE_CLK) begin
      if (SRST) begin
         half_q      <= 1'b0;
         div_cnt_q   <= 3'h0;
         conv_tick_q <= 1'b0;
      end else begin
         half_q      <= ~half_q;
         div_cnt_q   <= div_cnt_d;
         conv_tick_q <= conv_tick_d;
      end
   end

   assign CONV_CLK_EN = conv_tick_q;

   assign pins_all   = {pin_mid_q, pin_low_q};
   assign ANALOG_SEL = pins_all[NUM_CH-1:0];

   // Port override per channel while the pin serves as analog input
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_pin
         assign PIN_OUT[ch]    = PORT_OUT[ch] & ~ANALOG_SEL[ch];
         assign PIN_OE[ch]     = PORT_OE[ch] & ~ANALOG_SEL[ch];
         assign PIN_PULLUP[ch] = PORT_PULLUP[ch] & ~ANALOG_SEL[ch];
         assign PIN_IN_EN[ch]  = ~ANALOG_SEL[ch];
         assign PORT_IN[ch]    = PIN_IN[ch] & ~ANALOG_SEL[ch];
      end
   endgenerate

endmodule
`default_nettype wire

//--- src/acpc_regs.vh
/*
 * Register map and field layout of the converter configuration and
 * analog pin control block. Included by the design file by bare name.
 */
`ifndef ACPC_REGS_VH
`define ACPC_REGS_VH

`define ACPC_ADDR_W          2
`define ACPC_OFS_CONFIG      2'h0
`define ACPC_OFS_PIN_LOW     2'h1
`define ACPC_OFS_PIN_MID     2'h2
`define ACPC_OFS_STATUS      2'h3

`define ACPC_BIT_LOW_POWER   7
`define ACPC_DIV_HI          6
`define ACPC_DIV_LO          5
`define ACPC_BIT_LONG_SMP    4
`define ACPC_MODE_HI         3
`define ACPC_MODE_LO         2
`define ACPC_CLK_HI          1
`define ACPC_CLK_LO          0

`define ACPC_MODE_8BIT       2'h0
`define ACPC_MODE_10BIT      2'h2
`define ACPC_SRC_BUS         2'h0
`define ACPC_SRC_BUS_HALF    2'h1
`define ACPC_SRC_ALT         2'h2
`define ACPC_SRC_ASYNC       2'h3

`define ACPC_RST_CONFIG      8'h00
`define ACPC_RST_PINS        8'h00

`endif

//--- testbench/acpc_checker.sv
/* Assertions on the acpc_config_pin_ctrl ports.
   Bound to the design top; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module acpc_checker #(parameter NUM_CH = 16) (
   input wire logic              CORE_CLK,
   input wire logic              SRST,
   input wire logic [1:0]        ADDR,
   input wire logic [7:0]        WDATA,
   input wire logic              WR,
   input wire logic              RD,
   input wire logic [7:0]        RDATA,
   input wire logic              LOW_POWER,
   input wire logic              LONG_SAMPLE,
   input wire logic              MODE_10BIT,
   input wire logic              RESULT_INVALIDATE,
   input wire logic [1:0]        CLK_SOURCE,
   input wire logic [NUM_CH-1:0] PORT_OE,
   input wire logic [NUM_CH-1:0] PIN_OE,
   input wire logic [NUM_CH-1:0] ANALOG_SEL
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   low_power_a: assert property (WR && ADDR == 2'h0 |=> LOW_POWER == $past(WDATA[7]))
      else $error("low power bit wrong");
   long_sample_a: assert property (WR && ADDR == 2'h0 |=> LONG_SAMPLE == $past(WDATA[4]))
      else $error("sample bit wrong");
   width_mode_a: assert property (WR && ADDR == 2'h0 |=> MODE_10BIT == ($past(WDATA[3:2]) == 2'h2))
      else $error("width decode wrong");
   clock_source_a: assert property (WR && ADDR == 2'h0 |=> CLK_SOURCE == $past(WDATA[1:0]))
      else $error("source wrong");
   pin_low_a: assert property (WR && ADDR == 2'h1 |=> ANALOG_SEL[7:0] == $past(WDATA))
      else $error("low pins wrong");
   pin_mid_a: assert property (WR && ADDR == 2'h2 |=> ANALOG_SEL[15:8] == $past(WDATA))
      else $error("mid pins wrong");
   pin_gate_a: assert property (PIN_OE == (PORT_OE & ~ANALOG_SEL))
      else $error("drive not gated");
   read_idle_a: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not idle");
   invalidate_cause_a: assert property (!WR |=> !RESULT_INVALIDATE)
      else $error("invalidate without write");
   read_low_a: assert property (RD && ADDR == 2'h1 |=> RDATA == $past(ANALOG_SEL[7:0]))
      else $error("low pin readback wrong");
   reset_state_a: assert property ($fell(SRST) |->
      CLK_SOURCE == 2'h0 && ANALOG_SEL == '0 && RDATA == 8'h00)
      else $error("state after reset wrong");
endmodule
bind acpc_config_pin_ctrl acpc_checker #(.NUM_CH(NUM_CH)) u_chk (.CORE_CLK, .SRST, .ADDR,
   .WDATA, .WR, .RD, .RDATA, .LOW_POWER, .LONG_SAMPLE, .MODE_10BIT, .RESULT_INVALIDATE,
   .CLK_SOURCE, .PORT_OE, .PIN_OE, .ANALOG_SEL);
`default_nettype wire

//--- testbench/acpc_config_pin_ctrl_tb.sv
/* Bench with register model for acpc_config_pin_ctrl.
   Assumes the one-cycle register port and a 50 ns clock. */
`timescale 1ns/10ps
`default_nettype none
module acpc_config_pin_ctrl_tb;
   logic        CORE_CLK = 0, SRST = 1, WR = 0, RD = 0, ALT_CLK_EN = 0, ASYNC_CLK_EN = 0;
   logic        RESULT_CAPTURED = 0, vld = 0;
   logic [1:0]  ADDR = 0, CLK_SOURCE;
   logic [7:0]  WDATA = 0, RDATA, cfg = 0, lo = 0, mid = 0;
   logic [15:0] PORT_OUT = 0, PORT_OE = 0, PORT_PULLUP = 0, PIN_IN = 0, m;
   logic [15:0] PIN_OUT, PIN_OE, PIN_PULLUP, PIN_IN_EN, PORT_IN, ANALOG_SEL;
   logic        CONV_CLK_EN, LOW_POWER, LONG_SAMPLE, MODE_10BIT, MODE_RESERVED, RESULT_INVALIDATE;
   logic [31:0] r = 32'hE260BC2D;
   int          errors = 0, checks = 0, cyc = 0, n;
   always #25 CORE_CLK = ~CORE_CLK;
   // Odd tick spacing so a swapped source shows in the count
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      ALT_CLK_EN <= cyc % 3 == 0;
      ASYNC_CLK_EN <= cyc % 5 == 0;
   end
   acpc_config_pin_ctrl uut (.CORE_CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .ALT_CLK_EN,
      .ASYNC_CLK_EN, .CONV_CLK_EN, .LOW_POWER, .LONG_SAMPLE, .MODE_10BIT, .MODE_RESERVED,
      .CLK_SOURCE, .RESULT_INVALIDATE, .RESULT_CAPTURED, .PORT_OUT, .PORT_OE,
      .PORT_PULLUP, .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_PULLUP, .PIN_IN_EN, .PORT_IN, .ANALOG_SEL);
   function automatic [31:0] xs(input [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task chk(input [79:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr(input [1:0] a, input [7:0] d);
      logic [7:0] old;
      old = cfg;
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1;
      @(posedge CORE_CLK);
      WR <= 0;
      if (a == 0) cfg = d;
      if (a == 1) lo = d;
      if (a == 2) mid = d;
      #1 chk(RESULT_INVALIDATE, a == 0 && old[3:2] != d[3:2]);
      chk({LOW_POWER, LONG_SAMPLE, MODE_10BIT, MODE_RESERVED, CLK_SOURCE, ANALOG_SEL},
         {cfg[7], cfg[4], cfg[3:2] == 2'h2, cfg[2], cfg[1:0], mid, lo});
   endtask
   task rd(input [1:0] a, input [7:0] e);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD <= 1;
      @(posedge CORE_CLK);
      RD <= 0;
      #1 chk(RDATA, e);
   endtask
   task rst_chk;
      for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
      chk({CLK_SOURCE, ANALOG_SEL}, 18'h0);
   endtask
   initial begin
      repeat (20) @(posedge CORE_CLK);
      SRST <= 0;
      rst_chk;
      $display("reset test done");
      repeat (40) begin
         @(posedge CORE_CLK);
         r = xs(r);
         {PORT_OUT, PORT_OE} <= r;
         r = xs(r);
         {PORT_PULLUP, PIN_IN} <= r;
         RESULT_CAPTURED <= r[10];
         // Capture wins over a same-cycle width change
         vld = r[10] | (vld & !(r[9:8] == 0 && cfg[3:2] != r[3:2]));
         wr(r[9:8], r[7:0]);
         rd(r[9:8], r[9:8] == 3 ? {6'h00, cfg[2], vld} : r[9] ? mid : r[8] ? lo : cfg);
         m = {mid, lo};
         chk({PIN_OUT, PIN_OE, PIN_PULLUP, PIN_IN_EN, PORT_IN},
            {PORT_OUT & ~m, PORT_OE & ~m, PORT_PULLUP & ~m, ~m, PIN_IN & ~m});
      end
      $display("register test done");
      @(posedge CORE_CLK);
      SRST <= 1;
      RESULT_CAPTURED <= 0;
      repeat (2) @(posedge CORE_CLK);
      SRST <= 0;
      {cfg, lo, mid, vld} = 0;
      rst_chk;
      $display("second reset test done");
      for (int s = 0; s < 4; s++) for (int d = 0; d < 4; d++) begin
         wr(0, {1'b0, d[1:0], 3'h0, s[1:0]});
         repeat (16) @(posedge CORE_CLK);
         n = 0;
         repeat (240) begin
            @(posedge CORE_CLK);
            #1 if (CONV_CLK_EN === 1'b1) n++;
         end
         chk(n, 240 / ((1 << d) * (s == 0 ? 1 : s == 1 ? 2 : s == 2 ? 3 : 5)));
      end
      $display("divider test done");
      end_sim;
   end
   initial begin
      #(50 * 12000);
      errors++;
      end_sim;
   end
endmodule
`default_nettype wire
